// ===== verilog/rtam_alarm_mux.sv
// Purpose: dual alarm match registers and multi-function pin selector
// Assumes: timekeeping values and square wave come from logic on aclk
// Notes:   pin is open drain; only the low level is actively driven
//
// Function
// - minute match: tens bits 6-4, top zero
// - hour format bit mirrors timekeeping hour register
// - 12h: bit5 half day, bit4 tens
// - 24h: bits 5-4 tens, 3-0 ones
// - weekday bit7 picks asserted pin level
// - compare select code picks compared fields
// - hour compare honours 12/24 and half day
// - match sets sticky flag, host clears
// - flag re-sets while match persists
// - weekday write clears flag, never sets
// - weekday value in bits 2-0
// - date match: tens bits 5-4, 7-6 zero
// - month match: tens bit4, 7-5 zero
// - pin mode: square, alarm, else gpio
// - backup supply: only alarm mode works
// - one alarm: pin follows flag by polarity
// - two alarms: OR or inverted AND
// - gpio mode: pin equals control level bit
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
module rtam_alarm_mux (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic                       ce,
	// register bus, write address
	input  wire logic                       awvalid,
	output logic                            awready,
	input  wire logic [rtam_pkg::ADDR_W-1:0] awaddr,
	// write data
	input  wire logic                       wvalid,
	output logic                            wready,
	input  wire logic [31:0]                wdata,
	input  wire logic [3:0]                 wstrb,
	// write response
	output logic                            bvalid,
	input  wire logic                       bready,
	output logic [1:0]                      bresp,
	// read address
	input  wire logic                       arvalid,
	output logic                            arready,
	input  wire logic [rtam_pkg::ADDR_W-1:0] araddr,
	// read data
	output logic                            rvalid,
	input  wire logic                       rready,
	output logic [31:0]                     rdata,
	output logic [1:0]                      rresp,
	// timekeeping register images
	input  wire logic [7:0]                 tk_second,
	input  wire logic [7:0]                 tk_minute,
	input  wire logic [7:0]                 tk_hour,
	input  wire logic [7:0]                 tk_weekday,
	input  wire logic [7:0]                 tk_date,
	input  wire logic [7:0]                 tk_month,
	// divider output and supply state
	input  wire logic                       square_wave_in,
	input  wire logic                       on_backup_supply,
	// open-drain multi-function pin
	output logic                            multi_function_pin_out,
	output logic                            multi_function_pin_oe
);
	import rtam_pkg::*;

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [7:0]         areg_ff [NUM_ALM][NUM_FLD]; // alarm images
	logic [7:0]         ctrl_ff;                    // control image
	logic [NUM_ALM-1:0] flag_ff;                    // sticky match flags
	logic               oe_ff;                      // pin pull-low

	// write channel holding state
	logic               aw_held_ff;
	logic               w_held_ff;
	logic [5:0]         wr_idx_ff;   // word index of held address
	logic [7:0]         wbyte_ff;    // low byte of held data
	logic               wlane_ff;    // low byte lane enabled
	logic               bvalid_ff;
	logic [1:0]         bresp_ff;

	// read channel state
	logic               rvalid_ff;
	logic [7:0]         rbyte_ff;
	logic [1:0]         rresp_ff;

	// ------------------------------------------------------------
	// combinational nets
	// ------------------------------------------------------------
	logic [7:0]         tk_w [NUM_FLD];       // timekeeping by slot
	logic [7:0]         view_w [NUM_ALM][NUM_FLD]; // read images
	logic [NUM_ALM-1:0] match_w;              // live match per alarm
	logic [NUM_ALM-1:0] wk_wr_w;              // weekday register written
	logic [NUM_ALM-1:0] pol_w;                // polarity per alarm
	logic [NUM_ALM-1:0] en_w;                 // enable per alarm
	logic [7:0]         rd_acc [NUM_ALM*NUM_FLD+1]; // read mux chain
	logic [NUM_ALM*NUM_FLD:0] rd_hit_acc;     // read hit chain
	logic [NUM_ALM*NUM_FLD:0] wr_hit_acc;     // write hit chain
	logic               wr_fire;              // write performed now
	logic               ar_fire;              // read taken now
	logic [5:0]         rd_idx;               // word index of read
	logic               ctl_wr;               // control written
	rtam_mode_t         mode_w;               // selected pin mode
	logic               alarm_lvl;            // alarm-mode pin level
	logic               pin_lvl;              // selected pin level
	logic               released;             // mode unavailable on backup
	logic               nxt_oe;               // next pull-low

	// slot view of the timekeeping inputs
	assign tk_w[F_SEC]   = tk_second;
	assign tk_w[F_MIN]   = tk_minute;
	assign tk_w[F_HOUR]  = tk_hour;
	assign tk_w[F_DAY_OF_WEEK_VALUE] = tk_weekday;
	assign tk_w[F_DATE]  = tk_date;
	assign tk_w[F_MTH]   = tk_month;

	// ------------------------------------------------------------
	// register bus handshakes
	// ------------------------------------------------------------
	// readies drop with ce so nothing is taken while frozen
	assign awready = ce & ~aw_held_ff;
	assign wready  = ce & ~w_held_ff;
	assign arready = ce & ~rvalid_ff;
	assign bvalid  = bvalid_ff;
	assign bresp   = bresp_ff;
	assign rvalid  = rvalid_ff;
	assign rresp   = rresp_ff;
	assign rdata   = {24'h000000, rbyte_ff};

	// write happens once address and data are both held
	assign wr_fire = aw_held_ff & w_held_ff & ~bvalid_ff;
	assign ar_fire = arvalid & arready;
	assign rd_idx  = araddr[ADDR_W-1:2];
	assign ctl_wr  = wr_fire & (wr_idx_ff == IDX_CONTROL);

	// write address capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			wr_idx_ff  <= 6'h00;
		end else if (ce) begin
			if (awvalid & awready) begin
				aw_held_ff <= 1'b1;
				wr_idx_ff  <= awaddr[ADDR_W-1:2];
			end else if (wr_fire) begin
				aw_held_ff <= 1'b0;
			end
		end
	end

	// write data capture, only the low lane carries register bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_ff <= 1'b0;
			wbyte_ff  <= 8'h00;
			wlane_ff  <= 1'b0;
		end else if (ce) begin
			if (wvalid & wready) begin
				w_held_ff <= 1'b1;
				wbyte_ff  <= wdata[7:0];
				wlane_ff  <= wstrb[0];
			end else if (wr_fire) begin
				w_held_ff <= 1'b0;
			end
		end
	end

	// write response, unmapped index answers slave error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
		end else if (ce) begin
			if (wr_fire) begin
				bvalid_ff <= 1'b1;
				bresp_ff  <= wr_hit_acc[NUM_ALM*NUM_FLD] ? RESP_OKAY : RESP_SLVERR;
			end else if (bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// read answer, registered on the same edge that takes the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rbyte_ff  <= 8'h00;
			rresp_ff  <= RESP_OKAY;
		end else if (ce) begin
			if (ar_fire) begin
				rvalid_ff <= 1'b1;
				rbyte_ff  <= rd_acc[NUM_ALM*NUM_FLD];
				rresp_ff  <= rd_hit_acc[NUM_ALM*NUM_FLD] ? RESP_OKAY : RESP_SLVERR;
			end else if (rready) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------
	// low nibble is plain storage for oscillator, trim and divider
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff <= RST_CONTROL;
		end else if (ce && ctl_wr && wlane_ff) begin
			ctrl_ff <= wbyte_ff;
		end
	end

	// chain heads: control register is the first decode term
	assign rd_acc[0]     = (rd_idx == IDX_CONTROL) ? ctrl_ff : 8'h00;
	assign rd_hit_acc[0] = (rd_idx == IDX_CONTROL);
	assign wr_hit_acc[0] = (wr_idx_ff == IDX_CONTROL);

	// ------------------------------------------------------------
	// alarm units
	// ------------------------------------------------------------
	for (genvar i = 0; i < NUM_ALM; i++) begin : g_alm
		logic [NUM_FLD-1:0] eq_w;     // per-field equality
		logic [NUM_FLD-1:0] wr_sel;   // per-field write select
		logic [2:0]         sel_w;    // compare select code
		logic               sel_eq;   // selected fields all equal

		assign sel_w    = areg_ff[i][F_DAY_OF_WEEK_VALUE][MSK_LSB +: 3];
		assign pol_w[i] = areg_ff[i][F_DAY_OF_WEEK_VALUE][POL_BIT];
		assign en_w[i]  = ctrl_ff[CTL_EN0 + i];

		for (genvar k = 0; k < NUM_FLD; k++) begin : g_fld
			localparam int N = i * NUM_FLD + k;
			// hour compare spans half-day and tens bits, so the
			// 12h and 24h encodings compare as stored
			assign eq_w[k] = ((areg_ff[i][k] & CMASK[k]) ==
				(tk_w[k] & CMASK[k]));
			assign wr_sel[k] = wr_fire & wlane_ff & (wr_idx_ff == IDX_ALM[i][k]);
			assign rd_hit_acc[N+1] = rd_hit_acc[N] | (rd_idx == IDX_ALM[i][k]);
			assign wr_hit_acc[N+1] = wr_hit_acc[N] | (wr_idx_ff == IDX_ALM[i][k]);
			assign rd_acc[N+1] = rd_acc[N] |
				((rd_idx == IDX_ALM[i][k]) ? view_w[i][k] : 8'h00);

			// store only writable bits; format and flag bits stay out
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					areg_ff[i][k] <= RST_ALM[k];
				end else if (ce && wr_sel[k]) begin
					areg_ff[i][k] <= wbyte_ff & WMASK[k];
				end
			end
		end

		// read images: hour shows live format, weekday shows flag
		assign view_w[i][F_SEC]   = areg_ff[i][F_SEC];
		assign view_w[i][F_MIN]   = areg_ff[i][F_MIN];
		assign view_w[i][F_HOUR]  = areg_ff[i][F_HOUR] |
			(8'(tk_hour[HR_FMT_BIT]) << HR_FMT_BIT);
		assign view_w[i][F_DAY_OF_WEEK_VALUE] = areg_ff[i][F_DAY_OF_WEEK_VALUE] |
			(8'(flag_ff[i]) << FLAG_BIT);
		assign view_w[i][F_DATE]  = areg_ff[i][F_DATE];
		assign view_w[i][F_MTH]   = areg_ff[i][F_MTH];

		// reserved codes select nothing, so they never match
		assign sel_eq = ((sel_w == SEL_SEC)   & eq_w[F_SEC])   |
				((sel_w == SEL_MIN)   & eq_w[F_MIN])   |
				((sel_w == SEL_HOUR)  & eq_w[F_HOUR])  |
				((sel_w == SEL_DAY_OF_WEEK_VALUE) & eq_w[F_DAY_OF_WEEK_VALUE]) |
				((sel_w == SEL_DATE)  & eq_w[F_DATE])  |
				((sel_w == SEL_ALL)   & (&eq_w));

		// comparison is live, so every counter update is seen
		assign match_w[i] = en_w[i] & sel_eq;

		// any accepted write to the weekday index clears
		assign wk_wr_w[i] = wr_fire & (wr_idx_ff == IDX_ALM[i][F_DAY_OF_WEEK_VALUE]);

		// set beats clear: a match held through the clear re-sets
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				flag_ff[i] <= 1'b0;
			end else if (ce) begin
				flag_ff[i] <= match_w[i] | (flag_ff[i] & ~wk_wr_w[i]);
			end
		end
	end

	// ------------------------------------------------------------
	// pin selector
	// ------------------------------------------------------------
	// square wave wins over the alarm enables
	assign mode_w = ctrl_ff[CTL_SQUARE_WAVE_ENABLE] ? MODE_SQUARE :
			(|en_w) ? MODE_ALARM : MODE_GPIO;

	// dual alarms share the first unit's polarity
	assign alarm_lvl = (&en_w) ?
			(pol_w[0] ? (|flag_ff) : ~(&flag_ff)) :
			en_w[0] ? (pol_w[0] ? flag_ff[0] : ~flag_ff[0]) :
			(pol_w[1] ? flag_ff[1] : ~flag_ff[1]);

	// level per mode
	always_comb begin
		case (mode_w)
			MODE_SQUARE: pin_lvl = square_wave_in;
			MODE_ALARM:  pin_lvl = alarm_lvl;
			MODE_GPIO:   pin_lvl = ctrl_ff[CTL_OUT];
			default:     pin_lvl = 1'b1;
		endcase
	end

	// on backup only the alarm output drives; others float high
	assign released = on_backup_supply & (mode_w != MODE_ALARM);
	assign nxt_oe   = ~pin_lvl & ~released;

	// registered pull-low, one edge behind its cause
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			oe_ff <= 1'b0;
		end else if (ce) begin
			oe_ff <= nxt_oe;
		end
	end

	// open drain: the pin only ever pulls low
	assign multi_function_pin_out = 1'b0;
	assign multi_function_pin_oe  = oe_ff;

endmodule

// ===== pkg/rtam_pkg.sv
// Purpose: shared constants and types of the alarm match and output selector
// Assumes: 8-bit register images, word index on the register bus
// Notes:   byte address of a register is four times its index
package rtam_pkg;

	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int ADDR_W  = 8;            // register bus byte address width
	localparam int NUM_ALM = 2;            // two alarm units
	localparam int NUM_FLD = 6;            // match registers per alarm

	// field slots inside one alarm unit
	localparam int F_SEC   = 0;
	localparam int F_MIN   = 1;
	localparam int F_HOUR  = 2;
	localparam int F_DAY_OF_WEEK_VALUE = 3;
	localparam int F_DATE  = 4;
	localparam int F_MTH   = 5;

	// ------------------------------------------------------------
	// register indices
	// ------------------------------------------------------------
	localparam logic [5:0] IDX_CONTROL = 6'h07;
	localparam logic [5:0] IDX_ALM [NUM_ALM][NUM_FLD] = '{
		'{6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f},
		'{6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16}};

	// ------------------------------------------------------------
	// reset values, writable bits, compared bits
	// ------------------------------------------------------------
	localparam logic [7:0] RST_ALM [NUM_FLD] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01};
	localparam logic [7:0] RST_CONTROL       = 8'h80;
	localparam logic [7:0] WMASK [NUM_FLD]   = '{8'h7f, 8'h7f, 8'h3f, 8'hf7, 8'h3f, 8'h1f};
	localparam logic [7:0] CMASK [NUM_FLD]   = '{8'h7f, 8'h7f, 8'h3f, 8'h07, 8'h3f, 8'h1f};

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int POL_BIT    = 7;         // output polarity, weekday register
	localparam int MSK_LSB    = 4;         // compare select, 3 bits
	localparam int FLAG_BIT   = 3;         // match flag, weekday register
	localparam int HR_FMT_BIT = 6;         // 12/24 format bit in hour registers
	localparam int CTL_OUT    = 7;         // general-purpose level
	localparam int CTL_SQUARE_WAVE_ENABLE  = 6;         // square-wave enable
	localparam int CTL_EN0    = 4;         // first alarm enable, next bit second

	// compare select codes
	localparam logic [2:0] SEL_SEC   = 3'h0;
	localparam logic [2:0] SEL_MIN   = 3'h1;
	localparam logic [2:0] SEL_HOUR  = 3'h2;
	localparam logic [2:0] SEL_DAY_OF_WEEK_VALUE = 3'h3;
	localparam logic [2:0] SEL_DATE  = 3'h4;
	localparam logic [2:0] SEL_ALL   = 3'h7;

	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// pin modes
	typedef enum logic [1:0] {MODE_GPIO, MODE_ALARM, MODE_SQUARE} rtam_mode_t;

endpackage

// ===== tb/rtam_alarm_mux_sva.sv
// Purpose: port-level checks of the alarm match and pin selector
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every instance of the design
`timescale 1ns/1ps
module rtam_alarm_mux_sva (
	input wire logic                         aclk,
	input wire logic                         aresetn,
	input wire logic                         ce,
	input wire logic                         awvalid,
	input wire logic                         awready,
	input wire logic                         wvalid,
	input wire logic                         wready,
	input wire logic                         bvalid,
	input wire logic                         bready,
	input wire logic [1:0]                   bresp,
	input wire logic                         arvalid,
	input wire logic                         arready,
	input wire logic [rtam_pkg::ADDR_W-1:0]  araddr,
	input wire logic                         rvalid,
	input wire logic                         rready,
	input wire logic [31:0]                  rdata,
	input wire logic [1:0]                   rresp,
	input wire logic [7:0]                   tk_hour,
	input wire logic                         multi_function_pin_oe
);
	import rtam_pkg::*;
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	wire       rtake = arvalid && arready;   // read address taken
	wire [5:0] ridx  = araddr[7:2];          // word index of the read
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	property p_fmt; rtake && ridx == IDX_ALM[0][F_HOUR]
		|=> rdata[6] == $past(tk_hour[6]) && rdata[31:7] == 25'h0; endproperty
	a_fmt: assert property (p_fmt) else $error("hour format bit not mirrored");
	property p_min; rtake && ridx == IDX_ALM[1][F_MIN] |=> rdata[31:7] == 25'h0; endproperty
	a_min: assert property (p_min) else $error("minute top bits not zero");
	property p_date; rtake && ridx == IDX_ALM[0][F_DATE] |=> rdata[31:6] == 26'h0; endproperty
	a_date: assert property (p_date) else $error("date top bits not zero");
	property p_mth; rtake && ridx == IDX_ALM[1][F_MTH] |=> rdata[31:5] == 27'h0; endproperty
	a_mth: assert property (p_mth) else $error("month top bits not zero");
	property p_unmap; rtake && ridx == 6'h00 |=> rresp == RESP_SLVERR && rdata == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
	property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp); endproperty
	a_rhold: assert property (p_rhold) else $error("read answer dropped early");
	property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
	a_bhold: assert property (p_bhold) else $error("write answer dropped early");
	property p_wr; awvalid && awready && wvalid && wready |-> ##[1:2] bvalid; endproperty
	a_wr: assert property (p_wr) else $error("write answer late");
	property p_ce; !ce |-> !awready && !wready && !arready; endproperty
	a_ce: assert property (p_ce) else $error("ready while clock enable low");
	property p_rst; $rose(aresetn) |-> !bvalid && !rvalid && !multi_function_pin_oe; endproperty
	a_rst: assert property (p_rst) else $error("outputs not idle after reset");
	// main scenarios reached
	c_pin: cover property ($rose(multi_function_pin_oe));
	c_err: cover property (rvalid && rresp == RESP_SLVERR);
	c_wr:  cover property (bvalid && bready);
endmodule
bind rtam_alarm_mux rtam_alarm_mux_sva u_sva (.*);

// ===== tb/rtam_host_model.sv
// Purpose: register bus host that programs the alarm block
// Assumes: AXI4-Lite, one write and one read at a time
// Notes:   handshakes sampled at the falling edge, acted on at the rising
`timescale 1ns/1ps
module rtam_host_model (
	input  wire logic                        aclk,
	output logic                             awvalid,
	input  wire logic                        awready,
	output logic [rtam_pkg::ADDR_W-1:0]      awaddr,
	output logic                             wvalid,
	input  wire logic                        wready,
	output logic [31:0]                      wdata,
	output logic [3:0]                       wstrb,
	input  wire logic                        bvalid,
	output logic                             bready,
	input  wire logic [1:0]                  bresp,
	output logic                             arvalid,
	input  wire logic                        arready,
	output logic [rtam_pkg::ADDR_W-1:0]      araddr,
	input  wire logic                        rvalid,
	output logic                             rready,
	input  wire logic [31:0]                 rdata,
	input  wire logic [1:0]                  rresp
);
	import rtam_pkg::*;
	// idle bus at time zero
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
	end
	// one register write; released payload is inverted so stale data never matches
	task automatic wr(input logic [5:0] idx, input logic [7:0] d, output logic [1:0] resp);
		logic a, w, b;
		@(posedge aclk);
		awaddr <= {idx, 2'h0};
		wdata <= {24'h0, d};
		wstrb <= 4'h1;
		{awvalid, wvalid, bready} <= 3'h7;
		b = 1'h0;
		while (!b) begin
			@(negedge aclk);
			a = awvalid && awready;
			w = wvalid && wready;
			b = bvalid && bready;
			resp = bresp;
			@(posedge aclk);
			if (a) {awvalid, awaddr} <= {1'h0, ~awaddr};
			if (w) {wvalid, wdata} <= {1'h0, ~wdata};
			if (b) bready <= 1'h0;
		end
	endtask
	// one register read
	task automatic rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] resp);
		logic a, r;
		@(posedge aclk);
		araddr <= {idx, 2'h0};
		{arvalid, rready} <= 2'h3;
		r = 1'h0;
		while (!r) begin
			@(negedge aclk);
			a = arvalid && arready;
			r = rvalid && rready;
			d = rdata;
			resp = rresp;
			@(posedge aclk);
			if (a) {arvalid, araddr} <= {1'h0, ~araddr};
			if (r) rready <= 1'h0;
		end
	endtask
endmodule

// ===== tb/rtam_alarm_mux_tb.sv
// Purpose: self-checking bench of the alarm match and pin selector
// Assumes: host model owns the register bus, bench drives the time values
// Notes:   pin level is the inverse of the open-drain enable (pull-up)
`timescale 1ns/1ps
module rtam_alarm_mux_tb;
	import rtam_pkg::*;
	typedef struct {logic [5:0] idx; logic [7:0] wd; logic [7:0] rd; logic [1:0] rs;} rtam_row_t;
	logic        aclk, aresetn, ce, sq, bk, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, pin_out, pin_oe;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, resp;
	logic [7:0]  tk [6];
	int          fails, tests_run, cyc;
	// index, written, read back, response; hour format input is 1 here
	rtam_row_t   rows [15] = '{'{6'h0a, 8'hff, 8'h7f, 2'h0}, '{6'h0b, 8'hff, 8'h7f, 2'h0},
		'{6'h0c, 8'hff, 8'h7f, 2'h0}, '{6'h0d, 8'hff, 8'hf7, 2'h0}, '{6'h0e, 8'hff, 8'h3f, 2'h0},
		'{6'h0f, 8'hff, 8'h1f, 2'h0}, '{6'h11, 8'hff, 8'h7f, 2'h0}, '{6'h12, 8'h55, 8'h55, 2'h0},
		'{6'h13, 8'h12, 8'h52, 2'h0}, '{6'h14, 8'hff, 8'hf7, 2'h0}, '{6'h15, 8'h31, 8'h31, 2'h0},
		'{6'h16, 8'h12, 8'h12, 2'h0}, '{6'h07, 8'h8f, 8'h8f, 2'h0}, '{6'h00, 8'hff, 8'h00, 2'h2},
		'{6'h3f, 8'h12, 8'h00, 2'h2}};
	// only the six defined compare codes are ever written
	logic [2:0]  sel [6] = '{SEL_SEC, SEL_MIN, SEL_HOUR, SEL_DAY_OF_WEEK_VALUE, SEL_DATE, SEL_ALL};
	// one value per field off from its reset image; hour differs only in bit 5, a tens bit in the 24h format used here
	logic [7:0]  mm [6] = '{8'h02, 8'h02, 8'h20, 8'h02, 8'h02, 8'h02};
	rtam_alarm_mux dut (.aclk, .aresetn, .ce, .awvalid, .awready, .awaddr, .wvalid, .wready,
		.wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
		.rready, .rdata, .rresp, .tk_second(tk[0]), .tk_minute(tk[1]), .tk_hour(tk[2]),
		.tk_weekday(tk[3]), .tk_date(tk[4]), .tk_month(tk[5]), .square_wave_in(sq),
		.on_backup_supply(bk), .multi_function_pin_out(pin_out), .multi_function_pin_oe(pin_oe));
	rtam_host_model host (.aclk, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
		.bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
	// ------------------------------------------------------------
	// clock and hang guard
	// ------------------------------------------------------------
	initial begin
		aclk = 1'h0;
		forever #50 aclk = ~aclk;
	end
	// whole run is well under a thousand cycles
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			results();
		end
	end
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// long enough for match, flag and pin flop to settle
	task automatic w4;
		repeat (4) @(posedge aclk);
	endtask
	task automatic results;
		$display("counts: tests_run=%0d fails=%0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{aresetn, ce, sq, bk} = 4'h4;
		tk = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01};
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		tk[2] <= 8'h40;
		@(posedge aclk);
		ce <= 1'h0;
		@(posedge aclk);
		ce <= 1'h1;
		foreach (rows[i]) begin
			host.wr(rows[i].idx, rows[i].wd, resp);
			chk(resp, rows[i].rs);
			host.rd(rows[i].idx, rd, resp);
			chk(rd, {24'h0, rows[i].rd});
		end
		$display("test register rows done");
		// second reset in mid-run, then reset images
		aresetn <= 1'h0;
		tk[2] <= 8'h00;
		@(posedge aclk);
		aresetn <= 1'h1;
		for (int a = 0; a < 2; a++)
			for (int f = 0; f < 6; f++) begin
				host.rd(IDX_ALM[a][f], rd, resp);
				chk(rd, {24'h0, RST_ALM[f]});
			end
		host.rd(IDX_CONTROL, rd, resp);
		chk(rd, 32'h80);
		chk(pin_oe, 1'h0);
		$display("test reset values done");
		// each code: its own field off blocks the flag, restoring it sets the flag
		host.wr(IDX_CONTROL, 8'h10, resp);
		for (int c = 0; c < 6; c++) begin
			tk[c] <= mm[c];
			// from the second code on, the first write still sees the previous code matching, so set wins
			// and the flag comes back; the second write meets no match and clears
			repeat (2) host.wr(IDX_ALM[0][F_DAY_OF_WEEK_VALUE], {1'h1, sel[c], 4'h1}, resp);
			w4();
			host.rd(IDX_ALM[0][F_DAY_OF_WEEK_VALUE], rd, resp);
			chk(rd[3], 1'h0);
			chk(pin_oe, 1'h1);
			tk[c] <= RST_ALM[c];
			w4();
			host.rd(IDX_ALM[0][F_DAY_OF_WEEK_VALUE], rd, resp);
			chk(rd[3], 1'h1);
			chk(pin_oe, 1'h0);
		end
		// clear while matching comes back; flag bit written as one never sets
		host.wr(IDX_ALM[0][F_DAY_OF_WEEK_VALUE], 8'hf1, resp);
		w4();
		host.rd(IDX_ALM[0][F_DAY_OF_WEEK_VALUE], rd, resp);
		chk(rd, 32'hf9);
		tk[5] <= 8'h02;
		host.wr(IDX_ALM[0][F_DAY_OF_WEEK_VALUE], 8'hf9, resp);
		w4();
		host.rd(IDX_ALM[0][F_DAY_OF_WEEK_VALUE], rd, resp);
		chk(rd, 32'hf1);
		$display("test match flags done");
		// both alarms: second matches on seconds from its reset image
		host.wr(IDX_CONTROL, 8'h30, resp);
		w4();
		chk(pin_oe, 1'h0);
		host.wr(IDX_ALM[0][F_DAY_OF_WEEK_VALUE], 8'h71, resp);
		w4();
		chk(pin_oe, 1'h0);
		tk[5] <= 8'h01;
		w4();
		chk(pin_oe, 1'h1);
		$display("test dual alarm done");
		// general purpose, square wave over alarms, then backup supply
		host.wr(IDX_CONTROL, 8'h00, resp);
		w4();
		chk(pin_oe, 1'h1);
		host.wr(IDX_CONTROL, 8'h70, resp);
		w4();
		chk(pin_oe, 1'h1);
		sq <= 1'h1;
		w4();
		chk(pin_oe, 1'h0);
		{bk, sq} <= 2'h2;
		w4();
		chk(pin_oe, 1'h0);
		host.wr(IDX_CONTROL, 8'h10, resp);
		w4();
		chk(pin_oe, 1'h1);
		host.wr(IDX_CONTROL, 8'h00, resp);
		w4();
		chk(pin_oe, 1'h0);
		chk(pin_out, 1'h0);
		$display("test pin modes done");
		results();
	end
endmodule
